//--- shared/rfs_pkg.sv
package rfs_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_CHAN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CUR_RED = 8'h01;
    localparam logic [7:0] ADDR_CUR_BLUE = 8'h03;
    localparam logic [7:0] ADDR_BRIGHT = 8'h04;
    localparam logic [7:0] ADDR_MEAS_CTRL = 8'h06;
    localparam logic [7:0] ADDR_RES_UPPER = 8'h07;
    localparam logic [7:0] ADDR_RES_LOWER = 8'h08;

    // ==========================================
    // Field positions and reset values
    localparam int EN_LSB = 0;
    localparam int FAST_BIT = 3;
    localparam int AUTO_BIT = 4;
    localparam int FADE_BIT = 5;
    localparam int SEQ_LSB = 6;
    localparam int COMP_SEL_BIT = 4;
    localparam int READ_SEL_BIT = 5;
    localparam logic [7:0] CHAN_CTRL_RESET = 8'h08;
    localparam logic [7:0] MEAS_CTRL_RESET = 8'h00;
    localparam logic [2:0] BRIGHT_RESET = 3'h0;
    localparam logic [7:0] CUR_RESET = 8'h00;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_CYCLE_US = 820;
    localparam int PWM_STEPS = 4096;
    localparam int PWM_TICK_CYCLES = PWM_CYCLE_US * 1000 / (CLK_PERIOD_NS * PWM_STEPS);
    localparam int FADE_TIME_MS = 520;
    localparam int FADE_STEPS = FADE_TIME_MS * 1000 / PWM_CYCLE_US;
    localparam logic [16:0] FRAC_ONE = 17'h10000;
    localparam logic [16:0] FRAC_STEP = 17'((32'h10000 + FADE_STEPS - 1) / FADE_STEPS);
    localparam int AVG_WINDOW_MS = 134;
    localparam int AVG_SAMPLES = 256;
    localparam int AVG_SHIFT = 8;
    localparam int SAMPLE_CYCLES = AVG_WINDOW_MS * 1000000 / (CLK_PERIOD_NS * AVG_SAMPLES);

    // ==========================================
    // Modes and states
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_SEQ2 = 2'h1,
        MODE_SEQ3 = 2'h2,
        MODE_SEQ4 = 2'h3
    } rfs_mode_t;

    typedef enum logic {
        FADE_IDLE = 1'b0,
        FADE_RUN = 1'b1
    } rfs_fade_state_t;
endpackage

//--- shared/rfs_fade_if.sv
`timescale 1ns/1ns
interface rfs_fade_if;
    logic start;
    logic cycle;
    logic busy;
    logic [16:0] frac;

    modport ctl (
        input start,
        input cycle,
        output busy,
        output frac
    );
    modport user (
        output start,
        output cycle,
        input busy,
        input frac
    );
endinterface

//--- hdl/rfs_fade_ctl.sv
`timescale 1ns/1ns
module rfs_fade_ctl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fade handshake
    rfs_fade_if.ctl fade
);
    rfs_pkg::rfs_fade_state_t state_q;
    logic [9:0] cnt_q;
    logic [16:0] frac_q;
    logic last_w;
    logic [16:0] frac_inc_w;

    // ==========================================
    // Fixed-length ramp, one step per PWM cycle
    assign last_w = (cnt_q == 10'(rfs_pkg::FADE_STEPS - 1));
    assign frac_inc_w = (frac_q > rfs_pkg::FRAC_ONE - rfs_pkg::FRAC_STEP) ?
                        rfs_pkg::FRAC_ONE : frac_q + rfs_pkg::FRAC_STEP;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= rfs_pkg::FADE_IDLE;
            cnt_q <= 10'h000;
            frac_q <= 17'h00000;
        end else if (fade.start) begin
            // Restart from the present level, so a new change mid-fade never jumps
            state_q <= rfs_pkg::FADE_RUN;
            cnt_q <= 10'h000;
            frac_q <= 17'h00000;
        end else begin
            unique case (state_q)
                rfs_pkg::FADE_IDLE: begin
                    cnt_q <= 10'h000;
                end
                rfs_pkg::FADE_RUN: begin
                    if (fade.cycle) begin
                        cnt_q <= cnt_q + 10'h001;
                        frac_q <= last_w ? rfs_pkg::FRAC_ONE : frac_inc_w; // [R7] [R23]
                        if (last_w) begin
                            state_q <= rfs_pkg::FADE_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign fade.busy = (state_q == rfs_pkg::FADE_RUN);
    assign fade.frac = frac_q;
endmodule

//--- hdl/rfs_avg.sv
`timescale 1ns/1ns
module rfs_avg (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Converter samples
    input wire logic valid,
    input wire logic [11:0] sample,
    // Averaged result
    output logic [11:0] result,
    output logic updated
);
    logic [19:0] sum_q;
    logic [7:0] cnt_q;
    logic [11:0] result_q;
    logic updated_q;
    logic [19:0] sum_w;
    logic full_w;

    // ==========================================
    // Box average over a fixed number of samples
    assign sum_w = sum_q + {8'h00, sample};
    assign full_w = (cnt_q == 8'(rfs_pkg::AVG_SAMPLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum_q <= 20'h00000;
            cnt_q <= 8'h00;
            result_q <= 12'h000;
            updated_q <= 1'b0;
        end else begin
            updated_q <= valid && full_w;
            if (valid) begin
                cnt_q <= cnt_q + 8'h01;
                sum_q <= full_w ? 20'h00000 : sum_w;
                if (full_w) begin
                    result_q <= sum_w[rfs_pkg::AVG_SHIFT +: 12]; // [R16]
                end
            end
        end
    end

    assign result = result_q;
    assign updated = updated_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================
    // Checks
    avg_publish_a: assert property (valid && full_w |=> updated_q && cnt_q == 8'h00) // [R16]
        else $error("average not published after full window");
    avg_hold_a: assert property (!$past(valid) |-> $stable(result_q)) // [R15]
        else $error("average changed without a sample");
endmodule

//--- hdl/rfs_led_ctrl.sv
`timescale 1ns/1ns
// Function
// R1 - Bits 0..2 enable red, green, blue
// R2 - External input gates its channel normally
// R3 - External input triggers sequence when sequential
// R4 - Fade ramps on switching and brightness change
// R5 - Compensation value applied directly, never ramped
// R6 - Fade enable bit in channel control
// R7 - Every fade lasts fixed 520 ms
// R8 - All channels ramp together, keeping balance
// R9 - No fading in stand-alone mode
// R10 - Fade only in automatic mode
// R11 - Host writes zero to current registers
// R12 - Host sets brightness before enables
// R13 - Clearing automatic mode fades LEDs off
// R14 - 820 us PWM cycle, slow or fast
// R15 - Two 12-bit measurement inputs
// R16 - Results averaged over 134 ms
// R17 - Bit 5 selects readable result
// R18 - Host reads upper byte before lower
// R19 - Bit 4 selects compensation source
// R20 - Bits 7,6 select normal or sequence length
// R21 - 3-bit log brightness scales all channels
// R22 - Upper read latches matching lower byte
// R23 - Even steps per PWM cycle, exact end
module rfs_led_ctrl #(
    parameter int SAMPLE_CYCLES = rfs_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Pins
    input wire logic RED_EXT_MODULATION_IN,
    input wire logic GREEN_EXT_MODULATION_IN,
    input wire logic BLUE_EXT_MODULATION_IN,
    input wire logic STAND_ALONE_MODE,
    output logic RED_SINK_OUTPUT,
    output logic GREEN_SINK_OUTPUT,
    output logic BLUE_SINK_OUTPUT,
    // Converter
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [11:0] SENSOR_INPUT_ONE_DATA,
    input wire logic [11:0] SENSOR_INPUT_TWO_DATA,
    // Compensation source
    output logic [11:0] COMP_SENSOR_VALUE
);
    rfs_fade_if fade ();

    logic [7:0] ctrl_q;
    logic [7:0] mctl_q;
    logic [2:0] bri_q;
    logic [7:0] cur_q [3];
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [2:0] prev_q;
    logic auto_prev_q;
    logic [4:0] tick_cnt_q;
    logic [11:0] ph_q;
    logic [15:0] samp_cnt_q;
    logic conv_q;
    logic [7:0] hold_q;
    logic [7:0] rdata_q;
    logic [2:0] sink_q;
    logic [11:0] comp_q;
    logic [9:0] fade_cyc_q;

    logic [2:0] ext_s;
    logic [2:0] ext_rise;
    logic sa_s;
    logic auto_w;
    logic fast_w;
    rfs_pkg::rfs_mode_t seq_mode_w;
    logic seq_on_w;
    logic [2:0] seq_len_w;
    logic [11:0] bri_lvl_w;
    logic tick_w;
    logic fade_ok_w;
    logic [2:0] chg_w;
    logic fade_start_w;
    logic [2:0] sink_d;
    logic [11:0] res_one;
    logic [11:0] res_two;
    logic [11:0] sel_res_w;
    logic [11:0] comp_src_w;
    logic wr_cur_w;
    logic rd_upper_w;
    logic [7:0] rd_mux_w;

    // ==========================================
    // Decoding helpers
    function automatic logic [11:0] bri_level(input logic [2:0] code);
        bri_level = (code == 3'h7) ? 12'hfff : 12'(13'h1000 >> (3'h7 - code));
    endfunction

    // Red leads, green centred, blue trails, so pulses spread over the cycle
    function automatic logic pwm_hit(input logic [1:0] idx, input logic [11:0] p,
                                     input logic [11:0] lvl);
        logic [11:0] d;
        d = p + {1'b0, lvl[11:1]} - 12'h800;
        case (idx)
            2'h0: pwm_hit = p < lvl;
            2'h1: pwm_hit = d < lvl;
            default: pwm_hit = ~p < lvl;
        endcase
    endfunction

    // ==========================================
    // Pin synchronisers
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {STAND_ALONE_MODE, BLUE_EXT_MODULATION_IN,
                        GREEN_EXT_MODULATION_IN, RED_EXT_MODULATION_IN};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[2:0];
        end
    end

    assign ext_s = sync2_q[2:0];
    assign ext_rise = sync2_q[2:0] & ~prev_q;
    assign sa_s = sync2_q[3];

    // ==========================================
    // Control decode
    assign auto_w = ctrl_q[rfs_pkg::AUTO_BIT];
    assign fast_w = ctrl_q[rfs_pkg::FAST_BIT];
    assign seq_mode_w = rfs_pkg::rfs_mode_t'(ctrl_q[rfs_pkg::SEQ_LSB +: 2]); // [R20]
    assign seq_on_w = (seq_mode_w != rfs_pkg::MODE_NORMAL);
    assign seq_len_w = {1'b0, ctrl_q[rfs_pkg::SEQ_LSB +: 2]} + 3'h1; // [R20]
    assign bri_lvl_w = bri_level(bri_q); // [R21]
    // Auto-off edge still fades; plain manual operation never does
    assign fade_ok_w = ctrl_q[rfs_pkg::FADE_BIT] && !sa_s && (auto_w || auto_prev_q); // [R6] [R9] [R10] [R13]
    assign fade_start_w = fade_ok_w && (chg_w != 3'h0); // [R4]
    assign fade.start = fade_start_w;
    assign fade.cycle = tick_w && (ph_q == 12'hfff);

    rfs_fade_ctl u_fade (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .fade(fade)
    );

    // ==========================================
    // PWM timebase
    assign tick_w = (tick_cnt_q == 5'(rfs_pkg::PWM_TICK_CYCLES - 1));

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            tick_cnt_q <= 5'h00;
            ph_q <= 12'h000;
            auto_prev_q <= 1'b0;
            sink_q <= 3'h0;
        end else begin
            tick_cnt_q <= tick_w ? 5'h00 : tick_cnt_q + 5'h01; // [R14]
            ph_q <= tick_w ? ph_q + 12'h001 : ph_q;
            auto_prev_q <= auto_w;
            sink_q <= sink_d;
        end
    end

    // ==========================================
    // Channels
    for (genvar i = 0; i < 3; i++) begin : g_chan
        logic [11:0] tgt_w;
        logic [11:0] tgt_q;
        logic [11:0] start_q;
        logic [11:0] lvl_q;
        logic [11:0] sph_q;
        logic [2:0] rem_q;
        logic [29:0] mix_w;
        logic [11:0] interp_w;
        logic [11:0] p_w;
        logic [11:0] pf_w;
        logic gate_w;

        assign tgt_w = (auto_w && ctrl_q[rfs_pkg::EN_LSB + i]) ? bri_lvl_w : 12'h000; // [R1] [R21]
        assign chg_w[i] = (tgt_w != tgt_q);
        // One shared fraction keeps the colour ratio through the ramp
        assign mix_w = 30'(start_q) * 30'(rfs_pkg::FRAC_ONE - fade.frac)
                       + 30'(tgt_q) * 30'(fade.frac); // [R8]
        assign interp_w = mix_w[27:16];
        assign p_w = seq_on_w ? sph_q : ph_q;
        assign pf_w = fast_w ? {p_w[7:0], p_w[11:8]} : p_w; // [R14]
        assign gate_w = seq_on_w ? (rem_q != 3'h0) : ext_s[i]; // [R2] [R3]
        assign sink_d[i] = pwm_hit(2'(i), pf_w, lvl_q) && gate_w;

        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                tgt_q <= 12'h000;
                start_q <= 12'h000;
                lvl_q <= 12'h000;
            end else begin
                tgt_q <= tgt_w;
                if (fade_start_w) begin
                    start_q <= lvl_q;
                end
                lvl_q <= fade_start_w ? lvl_q : (fade.busy && !sa_s) ? interp_w : tgt_q; // [R4] [R23]
            end
        end

        // Sequence restarts the channel's own cycle on each trigger
        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                sph_q <= 12'h000;
                rem_q <= 3'h0;
            end else if (seq_on_w && ext_rise[i]) begin
                sph_q <= 12'h000;
                rem_q <= seq_len_w; // [R3] [R20]
            end else if (tick_w) begin
                sph_q <= sph_q + 12'h001;
                if (sph_q == 12'hfff && rem_q != 3'h0) begin
                    rem_q <= rem_q - 3'h1;
                end
            end
        end

        seq_trig_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [R3]
            seq_on_w && ext_rise[i] |=> rem_q == $past(seq_len_w) && sph_q == 12'h000)
            else $error("sequence trigger not taken");
        fade_end_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [R23]
            $fell(fade.busy) && !fade_start_w |=> lvl_q == $past(tgt_q))
            else $error("fade did not end on target");
        ramp_track_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [R8]
            fade.busy && !fade_start_w && !sa_s |=> lvl_q == $past(interp_w))
            else $error("channel left shared ramp");
    end

    // ==========================================
    // Converter timing and averaging
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            samp_cnt_q <= 16'h0000;
            conv_q <= 1'b0;
            comp_q <= 12'h000;
        end else begin
            conv_q <= (samp_cnt_q == 16'(SAMPLE_CYCLES - 1));
            samp_cnt_q <= conv_q ? 16'h0000 : samp_cnt_q + 16'h0001;
            comp_q <= comp_src_w; // [R5]
        end
    end

    rfs_avg u_avg_one (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .valid(CONV_DONE),
        .sample(SENSOR_INPUT_ONE_DATA),
        .result(res_one),
        .updated()
    );

    rfs_avg u_avg_two (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .valid(CONV_DONE),
        .sample(SENSOR_INPUT_TWO_DATA),
        .result(res_two),
        .updated()
    );

    assign sel_res_w = mctl_q[rfs_pkg::READ_SEL_BIT] ? res_two : res_one; // [R15] [R17]
    assign comp_src_w = mctl_q[rfs_pkg::COMP_SEL_BIT] ? res_two : res_one; // [R19]

    // ==========================================
    // Register file
    assign wr_cur_w = REG_WR && REG_ADDR >= rfs_pkg::ADDR_CUR_RED
                      && REG_ADDR <= rfs_pkg::ADDR_CUR_BLUE;
    assign rd_upper_w = REG_RD && REG_ADDR == rfs_pkg::ADDR_RES_UPPER;
    assign rd_mux_w = (REG_ADDR == rfs_pkg::ADDR_CHAN_CTRL) ? ctrl_q :
                      (REG_ADDR == rfs_pkg::ADDR_CUR_RED) ? cur_q[0] :
                      (REG_ADDR == rfs_pkg::ADDR_CUR_RED + 8'h01) ? cur_q[1] :
                      (REG_ADDR == rfs_pkg::ADDR_CUR_BLUE) ? cur_q[2] :
                      (REG_ADDR == rfs_pkg::ADDR_BRIGHT) ? {5'h00, bri_q} :
                      (REG_ADDR == rfs_pkg::ADDR_MEAS_CTRL) ? mctl_q :
                      (REG_ADDR == rfs_pkg::ADDR_RES_UPPER) ? sel_res_w[11:4] :
                      (REG_ADDR == rfs_pkg::ADDR_RES_LOWER) ? hold_q : 8'h00;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            ctrl_q <= rfs_pkg::CHAN_CTRL_RESET;
            mctl_q <= rfs_pkg::MEAS_CTRL_RESET;
            bri_q <= rfs_pkg::BRIGHT_RESET;
            cur_q <= '{default: rfs_pkg::CUR_RESET};
        end else if (REG_WR) begin
            if (REG_ADDR == rfs_pkg::ADDR_CHAN_CTRL) begin
                ctrl_q <= REG_WDATA; // [R1] [R6]
            end
            if (REG_ADDR == rfs_pkg::ADDR_MEAS_CTRL) begin
                mctl_q <= REG_WDATA;
            end
            if (REG_ADDR == rfs_pkg::ADDR_BRIGHT) begin
                bri_q <= REG_WDATA[2:0];
            end
            if (wr_cur_w) begin
                cur_q[REG_ADDR[1:0] - 2'h1] <= REG_WDATA;
            end
        end
    end

    // Lower byte is frozen on the upper read, so the pair never tears
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            hold_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            if (rd_upper_w) begin
                hold_q <= {sel_res_w[3:0], 4'h0}; // [R18] [R22]
            end
            if (REG_RD) begin
                rdata_q <= rd_mux_w;
            end
        end
    end

    assign REG_RDATA = rdata_q;
    assign RED_SINK_OUTPUT = sink_q[0];
    assign GREEN_SINK_OUTPUT = sink_q[1];
    assign BLUE_SINK_OUTPUT = sink_q[2];
    assign CONV_START = conv_q;
    assign COMP_SENSOR_VALUE = comp_q;

    // ==========================================
    // Checks
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            fade_cyc_q <= 10'h000;
        end else if (fade_start_w) begin
            fade_cyc_q <= 10'h000;
        end else if (fade.busy && fade.cycle) begin
            fade_cyc_q <= fade_cyc_q + 10'h001;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    chan_en_a: assert property ((!ctrl_q[0] && !fade.busy && !fade_start_w)[*4] // [R1]
        |-> !RED_SINK_OUTPUT) else $error("disabled red output active");
    ext_gate_a: assert property (!seq_on_w && !ext_s[1] |=> !GREEN_SINK_OUTPUT) // [R2]
        else $error("green output ignored its gate");
    fade_start_a: assert property (fade_start_w |=> fade.busy && fade.frac == 17'h00000) // [R4]
        else $error("fade did not start");
    comp_direct_a: assert property (1'b1 |=> COMP_SENSOR_VALUE == $past(comp_src_w)) // [R5] [R19]
        else $error("compensation value delayed or wrong source");
    fade_bit_a: assert property (!ctrl_q[rfs_pkg::FADE_BIT] |-> !fade_start_w) // [R6]
        else $error("fade started while disabled");
    fade_span_a: assert property ($fell(fade.busy) |-> fade_cyc_q == 10'(rfs_pkg::FADE_STEPS)) // [R7]
        else $error("fade length wrong");
    stand_alone_a: assert property (sa_s |-> !fade_start_w) // [R9]
        else $error("fade in stand-alone mode");
    manual_a: assert property (!auto_w && !auto_prev_q |-> !fade_start_w) // [R10]
        else $error("fade in manual mode");
    auto_off_a: assert property ((!auto_w && !fade.busy && !fade_start_w)[*4] // [R13]
        |-> !RED_SINK_OUTPUT && !GREEN_SINK_OUTPUT && !BLUE_SINK_OUTPUT)
        else $error("outputs on without automatic mode");
    pwm_tick_a: assert property (tick_w |-> ##20 tick_w) // [R14]
        else $error("PWM step spacing wrong");
    read_sel_a: assert property (rd_upper_w |=> REG_RDATA == $past(sel_res_w[11:4])) // [R17]
        else $error("upper result byte wrong");
    hold_pair_a: assert property (rd_upper_w |=> hold_q == {$past(sel_res_w[3:0]), 4'h0}) // [R22]
        else $error("lower byte not latched");

    fade_done_c: cover property ($fell(fade.busy));
    seq_run_c: cover property (seq_on_w && ext_rise[0] ##1 g_chan[0].rem_q != 3'h0);
    result_read_c: cover property (rd_upper_w ##[1:4] (REG_RD && REG_ADDR == rfs_pkg::ADDR_RES_LOWER));
endmodule

//--- tb/rfs_conv_model.sv
`timescale 1ns/1ns
module rfs_conv_model #(
    parameter int LAT = 3,
    parameter logic [11:0] V1 = 12'ha5c,
    parameter logic [11:0] V2 = 12'h3e1
) (
    // Converter port
    input wire logic clk,
    input wire logic start,
    output logic done,
    output logic [11:0] d1,
    output logic [11:0] d2
);
    int cnt = 0;
    logic done_q = 1'b0;
    assign done = done_q;
    // Inverse outside the strobe, so a stale sample cannot match
    assign d1 = done ? V1 : ~V1;
    assign d2 = done ? V2 : ~V2;
    always @(posedge clk) begin
        done_q <= (cnt == 1);
        if (start)
            cnt <= LAT;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule

//--- tb/rfs_led_ctrl_bench.sv
`timescale 1ns/1ns
module rfs_led_ctrl_bench;
    // ==========================================
    // Signals
    localparam logic [11:0] V1 = 12'ha5c;
    localparam logic [11:0] V2 = 12'h3e1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] ext = 3'h7;
    logic sa = 1'b0;
    logic [2:0] sink;
    logic cstart;
    logic cdone;
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] comp;
    logic [11:0] v;
    int error_cnt = 0;
    int n_checks = 0;

    initial forever #5 clk = ~clk;

    // Small window keeps the averaging run short
    rfs_led_ctrl #(.SAMPLE_CYCLES(8)) dut (
        .CLOCK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
        .RED_EXT_MODULATION_IN(ext[0]), .GREEN_EXT_MODULATION_IN(ext[1]),
        .BLUE_EXT_MODULATION_IN(ext[2]), .STAND_ALONE_MODE(sa),
        .RED_SINK_OUTPUT(sink[0]), .GREEN_SINK_OUTPUT(sink[1]),
        .BLUE_SINK_OUTPUT(sink[2]), .CONV_START(cstart), .CONV_DONE(cdone),
        .SENSOR_INPUT_ONE_DATA(s1), .SENSOR_INPUT_TWO_DATA(s2),
        .COMP_SENSOR_VALUE(comp)
    );
    rfs_conv_model #(.V1(V1), .V2(V2)) conv (
        .clk(clk), .start(cstart), .done(cdone), .d1(s1), .d2(s2)
    );

    // ==========================================
    // Tasks
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        chk({4'h0, d}, {4'h0, e});
        @(posedge clk);
    endtask
    // Bounded poll; sink outputs are levels per PWM step
    task automatic wsink(input int ch, input logic lv);
        int i;
        i = 0;
        #1;
        while (sink[ch] !== lv && i < 300) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk({11'h0, sink[ch]}, {11'h0, lv});
        // Realign so the next stimulus lands on an edge
        @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(rfs_pkg::ADDR_CHAN_CTRL, rfs_pkg::CHAN_CTRL_RESET);
        rdchk(rfs_pkg::ADDR_MEAS_CTRL, 8'h00);
        wr_reg(8'h05, 8'hff);
        rdchk(8'h05, 8'h00);
        for (int c = 0; c < 3; c++)
            wsink(c, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr_reg(rfs_pkg::ADDR_CHAN_CTRL, {2'(m), 6'h00});
            rdchk(rfs_pkg::ADDR_CHAN_CTRL, {2'(m), 6'h00});
        end
        for (int r = 1; r < 4; r++)
            wr_reg(8'(r), 8'h00);
        wr_reg(rfs_pkg::ADDR_BRIGHT, 8'h07);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h17);
        for (int c = 0; c < 3; c++)
            wsink(c, 1'b1);
        ext[0] <= 1'b0;
        wsink(0, 1'b0);
        ext[0] <= 1'b1;
        wsink(0, 1'b1);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h16);
        wsink(0, 1'b0);
        wsink(1, 1'b1);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h57);
        wsink(1, 1'b0);
        ext[0] <= 1'b0;
        repeat (4) @(posedge clk);
        ext[0] <= 1'b1;
        wsink(0, 1'b1);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h07);
        for (int c = 0; c < 3; c++)
            wsink(c, 1'b0);
        // Pin needs the synchroniser delay before the write
        sa <= 1'b1;
        repeat (3) @(posedge clk);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h3f);
        wsink(2, 1'b1);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h07);
        wsink(2, 1'b0);
        sa <= 1'b0;
        repeat (3) @(posedge clk);
        wr_reg(rfs_pkg::ADDR_CHAN_CTRL, 8'h37);
        repeat (10) @(posedge clk);
        #1 chk({9'h0, sink}, 12'h000);
        repeat (3000) @(posedge clk);
        for (int s = 0; s < 2; s++) begin
            v = s ? V2 : V1;
            wr_reg(rfs_pkg::ADDR_MEAS_CTRL, s ? 8'h30 : 8'h00);
            rdchk(rfs_pkg::ADDR_RES_UPPER, v[11:4]);
            rdchk(rfs_pkg::ADDR_RES_LOWER, {v[3:0], 4'h0});
            rdchk(rfs_pkg::ADDR_RES_LOWER, {v[3:0], 4'h0});
            chk(comp, v);
        end
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
